// ===== shared/mfd_pkg.sv
/*
 * Constants, register map and state encoding for the motor fault
 * supervisor. Assumes a 250 MHz system clock.
 */
package mfd_pkg;
    // timing
    localparam int unsigned SYS_CLK_HZ = 250_000_000;
    localparam int unsigned SAMPLE_HZ = 500;
    localparam int unsigned SAMPLE_CYCLES = SYS_CLK_HZ / SAMPLE_HZ;
    localparam int unsigned BAUD_RATE = 115200;
    localparam int unsigned BAUD_DIV = SYS_CLK_HZ / BAUD_RATE;
    // data widths and frame
    localparam int ADC_W = 12;
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] FRAME_LAST = 8'hFF;
    localparam int ACC_W = 21;
    localparam int FEAT_W = 22;
    localparam int GAIN_W = 16;
    localparam int DEG_W = 8;
    localparam int HARM_FIRST = 1;
    localparam int HARM_THIRD = 3;
    localparam logic [DEG_W-1:0] DEG_FULL = 8'hFF;
    // panel pin indices
    localparam int NPIN = 5;
    localparam int PIN_RUN = 0;
    localparam int PIN_CLR = 1;
    localparam int PIN_RBTN = 2;
    localparam int PIN_OVC = 3;
    localparam int PIN_FLT = 4;
    // register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_BIN = 12'h004;
    localparam logic [11:0] REG_GAIN = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam logic [11:0] REG_FEAT1 = 12'h010;
    localparam logic [11:0] REG_FEAT3 = 12'h014;
    localparam logic [11:0] REG_IRQ_STAT = 12'h018;
    localparam logic [11:0] REG_IRQ_MASK = 12'h01C;
    // fields and reset values
    localparam int CTRL_STREAM = 0;
    localparam logic CTRL_STREAM_RST = 1'b1;
    localparam logic [IDX_W-1:0] BIN_RST = 8'h04;
    localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0100;
    localparam int IRQ_W = 2;
    localparam int IRQ_ERR = 0;
    localparam int IRQ_FRAME = 1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    typedef enum logic [1:0] {
        ST_INACTIVE = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_ERROR = 2'b11
    } mfd_state_t;
endpackage

// ===== shared/mfd_feat_if.sv
/*
 * Sample stream into the harmonic extractor and features back out.
 * Assumes both ends share sys_clk_in.
 */
`timescale 1ns/10ps
interface mfd_feat_if;
    import mfd_pkg::*;
    logic smp_vld;
    logic [ADC_W-1:0] smp_data;
    logic [IDX_W-1:0] smp_idx;
    logic [IDX_W-1:0] bin;
    logic feat_vld;
    logic [FEAT_W-1:0] h1;
    logic [FEAT_W-1:0] h3;
    modport src(output smp_vld, smp_data, smp_idx, bin,
                input feat_vld, h1, h3);
    modport sink(input smp_vld, smp_data, smp_idx, bin,
                 output feat_vld, h1, h3);
endinterface

// ===== rtl/mfd_harm.sv
/*
 * Harmonic feature extractor: correlates each frame against square
 * waves at the fundamental bin and three times it.
 * Assumes samples arrive with their index, 0 to 255, in order.
 */
`timescale 1ns/10ps
module mfd_harm
    import mfd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // stream
    mfd_feat_if.sink fi
);
    function automatic logic [FEAT_W-1:0] absf(
        input logic signed [ACC_W-1:0] v);
        absf = FEAT_W'(v[ACC_W-1] ? -v : v);
    endfunction

    logic [FEAT_W-1:0] mag [2];
    logic last;
    assign last = fi.smp_vld && (fi.smp_idx == FRAME_LAST);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_harm
            logic signed [ACC_W-1:0] acc_i_reg, acc_q_reg;
            logic signed [ACC_W-1:0] smp, acc_i_next, acc_q_next;
            logic signed [ACC_W-1:0] base_i, base_q;
            logic [IDX_W-1:0] step, phase;
            // square-wave references cancel the dc term over a frame
            assign step = IDX_W'(fi.bin *
                (g == 0 ? HARM_FIRST : HARM_THIRD));
            assign phase = IDX_W'(fi.smp_idx * step);
            assign smp = ACC_W'(signed'({1'b0, fi.smp_data}));
            // index 0 opens a frame, so a cut frame leaves no residue
            assign base_i = (fi.smp_idx == '0) ? '0 : acc_i_reg;
            assign base_q = (fi.smp_idx == '0) ? '0 : acc_q_reg;
            assign acc_i_next = (phase[IDX_W-1] ^ phase[IDX_W-2]) ?
                base_i - smp : base_i + smp;
            assign acc_q_next = phase[IDX_W-1] ?
                base_q - smp : base_q + smp;
            assign mag[g] = absf(acc_i_next) + absf(acc_q_next);
            always_ff @(posedge sys_clk_in) begin
                if (srst_in || last) begin
                    acc_i_reg <= '0;
                    acc_q_reg <= '0;
                end else if (fi.smp_vld) begin
                    acc_i_reg <= acc_i_next;
                    acc_q_reg <= acc_q_next;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            fi.feat_vld <= 1'b0;
            fi.h1 <= '0;
            fi.h3 <= '0;
        end else begin
            fi.feat_vld <= last;
            if (last) begin
                fi.h1 <= mag[0];
                fi.h3 <= mag[1];
            end
        end
    end

    AST_FRAME_FEAT: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        last |=> fi.feat_vld ##1 !fi.feat_vld)
        else $error("features not produced once per frame");
endmodule

// ===== rtl/mfd_uart_tx.sv
/*
 * Transmit-only 8N1 serial port.
 * Assumes a byte is offered only while ready is high.
 */
`timescale 1ns/10ps
module mfd_uart_tx
    import mfd_pkg::*;
#(
    parameter int unsigned DIV = BAUD_DIV
)(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // byte in
    input wire logic [7:0] data_in,
    input wire logic vld_in,
    output logic rdy_out,
    // line
    output logic tx_out
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] baud_reg;
    logic [9:0] shf_reg;
    logic [3:0] bits_reg;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            baud_reg <= '0;
            shf_reg <= '1;
            bits_reg <= '0;
            rdy_out <= 1'b1;
            tx_out <= 1'b1;
        end else if (rdy_out) begin
            if (vld_in) begin
                shf_reg <= {1'b1, data_in, 1'b0};
                bits_reg <= 4'hA;
                baud_reg <= CW'(DIV - 1);
                rdy_out <= 1'b0;
                tx_out <= 1'b0;
            end
        end else if (baud_reg != '0) begin
            baud_reg <= baud_reg - 1'b1;
        end else begin
            baud_reg <= CW'(DIV - 1);
            shf_reg <= {1'b1, shf_reg[9:1]};
            tx_out <= shf_reg[1];
            bits_reg <= bits_reg - 1'b1;
            if (bits_reg == 4'h1) begin
                rdy_out <= 1'b1;
                tx_out <= 1'b1;
            end
        end
    end

    AST_UART_START: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        rdy_out && vld_in |=> !tx_out && !rdy_out)
        else $error("start bit not sent");
endmodule

// ===== rtl/mfd_top.sv
/*
 * Motor fault supervisor: run/error state machine, panel lamps,
 * speed command, current sampling, frame features, abnormality
 * degree, serial stream to the PC and an APB register file.
 * Assumes panel pins are asynchronous; ADC and knob are on sys_clk_in.
 */
`timescale 1ns/10ps
// Summary of operation
// - start inactive, motor not driven
// - run switch on moves inactive to active
// - error while inactive enters error state
// - active lights run lamp, allows drive
// - error while active enters error state
// - overcurrent or fault lights error lamp
// - reset button or clear on-off clears error
// - active speed follows speed knob
// - 12-bit current samples at sampling rate
// - 256-sample frames processed as unit
// - 0.5 kHz sampling, 115200 baud link
// - first and third harmonic features, no dc
// - normal and abnormal probabilities, abnormal reported
// - active state streams data to PC
module mfd_top
    import mfd_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV = SAMPLE_CYCLES
)(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // apb slave
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // panel pins
    input wire logic run_switch_in,
    input wire logic error_clear_switch_in,
    input wire logic reset_button_in,
    input wire logic overcurrent_in,
    input wire logic fault_in,
    // speed knob and adc unit
    input wire logic [ADC_W-1:0] speed_knob_in,
    input wire logic adc_done_in,
    input wire logic [ADC_W-1:0] adc_data_in,
    output logic adc_start_out,
    // lamps and drive
    output logic run_indicator_out,
    output logic error_indicator_out,
    output logic motor_drive_en_out,
    output logic [ADC_W-1:0] speed_cmd_out,
    // pc serial channel and interrupt
    output logic pc_serial_tx_out,
    output logic irq_out
);
    localparam int SW = $clog2(SAMPLE_DIV);

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == REG_CTRL) || (a == REG_BIN) ||
            (a == REG_GAIN) || (a == REG_STATUS) ||
            (a == REG_FEAT1) || (a == REG_FEAT3) ||
            (a == REG_IRQ_STAT) || (a == REG_IRQ_MASK);
    endfunction

    // pin synchronisers
    logic [NPIN-1:0] pin_raw, s1_reg, s2_reg, s3_reg, flt_reg;
    logic clr_prev_reg, clr_fall, err_evt;
    assign pin_raw = {fault_in, overcurrent_in, reset_button_in,
        error_clear_switch_in, run_switch_in};

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            flt_reg <= '0;
            clr_prev_reg <= 1'b0;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= (~(s2_reg ^ s3_reg) & s2_reg) |
                ((s2_reg ^ s3_reg) & flt_reg);
            clr_prev_reg <= flt_reg[PIN_CLR];
        end
    end
    assign clr_fall = clr_prev_reg && !flt_reg[PIN_CLR];
    assign err_evt = flt_reg[PIN_OVC] || flt_reg[PIN_FLT];

    // supervisory state machine
    mfd_state_t state_reg, state_next;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_INACTIVE: begin
                if (err_evt)
                    state_next = ST_ERROR;
                else if (flt_reg[PIN_RUN])
                    state_next = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (err_evt)
                    state_next = ST_ERROR;
                else if (flt_reg[PIN_RBTN] || !flt_reg[PIN_RUN])
                    state_next = ST_INACTIVE;
            end
            ST_ERROR: begin
                if (!err_evt && (flt_reg[PIN_RBTN] || clr_fall))
                    state_next = ST_INACTIVE;
            end
            default: state_next = ST_INACTIVE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_reg <= ST_INACTIVE;
            run_indicator_out <= 1'b0;
            error_indicator_out <= 1'b0;
            motor_drive_en_out <= 1'b0;
            speed_cmd_out <= '0;
        end else begin
            state_reg <= state_next;
            run_indicator_out <= state_next == ST_ACTIVE;
            motor_drive_en_out <= state_next == ST_ACTIVE;
            error_indicator_out <= state_next == ST_ERROR;
            speed_cmd_out <= (state_next == ST_ACTIVE) ?
                speed_knob_in : '0;
        end
    end

    // sampling and frame collection
    logic [SW-1:0] tick_reg;
    logic smp_vld_reg;
    logic [ADC_W-1:0] smp_data_reg;
    logic [IDX_W-1:0] smp_idx_reg, idx_reg;
    logic active, capture;
    logic ctrl_stream_reg;
    logic [IDX_W-1:0] bin_reg;
    assign active = state_reg == ST_ACTIVE;
    assign capture = active && adc_done_in;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            tick_reg <= '0;
            adc_start_out <= 1'b0;
        end else begin
            tick_reg <= (tick_reg == SW'(SAMPLE_DIV - 1)) ?
                '0 : tick_reg + 1'b1;
            adc_start_out <= active &&
                (tick_reg == SW'(SAMPLE_DIV - 1));
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in || !active) begin
            smp_vld_reg <= 1'b0;
            smp_data_reg <= '0;
            smp_idx_reg <= '0;
            idx_reg <= '0;
        end else begin
            smp_vld_reg <= capture;
            if (capture) begin
                smp_data_reg <= adc_data_in;
                smp_idx_reg <= idx_reg;
                idx_reg <= idx_reg + 1'b1;
            end
        end
    end

    mfd_feat_if fi();
    assign fi.smp_vld = smp_vld_reg;
    assign fi.smp_data = smp_data_reg;
    assign fi.smp_idx = smp_idx_reg;
    assign fi.bin = bin_reg;

    mfd_harm u_harm (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .fi(fi)
    );

    // classifier: abnormal share grows with third-harmonic energy
    logic [GAIN_W-1:0] gain_reg;
    logic [FEAT_W-1:0] h1_reg, h3_reg;
    logic [DEG_W-1:0] abn_reg, norm_reg, abn_next;
    logic [FEAT_W+GAIN_W-1:0] prod;
    assign prod = fi.h3 * gain_reg;
    assign abn_next = (|prod[FEAT_W+GAIN_W-1:GAIN_W]) ?
        DEG_FULL : prod[GAIN_W-1:GAIN_W-DEG_W];

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            h1_reg <= '0;
            h3_reg <= '0;
            abn_reg <= '0;
            norm_reg <= DEG_FULL;
        end else if (fi.feat_vld) begin
            h1_reg <= fi.h1;
            h3_reg <= fi.h3;
            abn_reg <= abn_next;
            norm_reg <= DEG_FULL - abn_next;
        end
    end

    // serial stream: sample high, sample low, then degree per frame
    logic hi_pend_reg, lo_pend_reg, deg_pend_reg;
    logic [ADC_W-1:0] tx_smp_reg;
    logic [DEG_W-1:0] tx_deg_reg, tx_byte;
    logic uart_rdy, take_hi, take_lo, take_deg, set_smp;
    assign set_smp = smp_vld_reg && ctrl_stream_reg;
    assign take_hi = uart_rdy && hi_pend_reg;
    assign take_lo = uart_rdy && !hi_pend_reg && lo_pend_reg;
    assign take_deg = uart_rdy && !hi_pend_reg && !lo_pend_reg &&
        deg_pend_reg;
    assign tx_byte = take_hi ? DEG_W'(tx_smp_reg >> DEG_W) :
        take_lo ? tx_smp_reg[DEG_W-1:0] : tx_deg_reg;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            hi_pend_reg <= 1'b0;
            lo_pend_reg <= 1'b0;
            deg_pend_reg <= 1'b0;
            tx_smp_reg <= '0;
            tx_deg_reg <= '0;
        end else begin
            hi_pend_reg <= (hi_pend_reg && !take_hi) || set_smp;
            lo_pend_reg <= (lo_pend_reg && !take_lo) || set_smp;
            deg_pend_reg <= (deg_pend_reg && !take_deg) ||
                (fi.feat_vld && active);
            if (set_smp)
                tx_smp_reg <= smp_data_reg;
            if (fi.feat_vld)
                tx_deg_reg <= abn_next;
        end
    end

    mfd_uart_tx #(.DIV(BAUD_DIV)) u_uart (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .data_in(tx_byte),
        .vld_in(take_hi || take_lo || take_deg),
        .rdy_out(uart_rdy),
        .tx_out(pc_serial_tx_out)
    );

    // apb register file, one wait-free access phase
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_evt;
    logic setup, wr;
    logic [31:0] rd_data;
    assign setup = psel_in && !penable_in;
    assign wr = psel_in && penable_in && pready_out && pwrite_in;

    always_comb begin
        rd_data = '0;
        case (paddr_in)
            REG_CTRL: rd_data[CTRL_STREAM] = ctrl_stream_reg;
            REG_BIN: rd_data = 32'(bin_reg);
            REG_GAIN: rd_data = 32'(gain_reg);
            REG_STATUS: rd_data = 32'({norm_reg, abn_reg,
                6'h00, state_reg});
            REG_FEAT1: rd_data = 32'(h1_reg);
            REG_FEAT3: rd_data = 32'(h3_reg);
            REG_IRQ_STAT: rd_data = 32'(irq_stat_reg);
            REG_IRQ_MASK: rd_data = 32'(irq_mask_reg);
            default: rd_data = '0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end else begin
            pready_out <= setup;
            pslverr_out <= setup && !addr_ok(paddr_in);
            if (setup)
                prdata_out <= pwrite_in ? '0 : rd_data;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            ctrl_stream_reg <= CTRL_STREAM_RST;
            bin_reg <= BIN_RST;
            gain_reg <= GAIN_RST;
            irq_mask_reg <= IRQ_MASK_RST;
        end else if (wr) begin
            case (paddr_in)
                REG_CTRL: ctrl_stream_reg <= pwdata_in[CTRL_STREAM];
                REG_BIN: bin_reg <= pwdata_in[IDX_W-1:0];
                REG_GAIN: gain_reg <= pwdata_in[GAIN_W-1:0];
                REG_IRQ_MASK: irq_mask_reg <= pwdata_in[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky events; a new event wins over a write-one clear
    assign irq_evt[IRQ_ERR] = state_next == ST_ERROR &&
        state_reg != ST_ERROR;
    assign irq_evt[IRQ_FRAME] = fi.feat_vld;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            irq_stat_reg <= '0;
            irq_out <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                ~((wr && paddr_in == REG_IRQ_STAT) ?
                pwdata_in[IRQ_W-1:0] : '0)) | irq_evt;
            irq_out <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    sequence clr_on_off;
        flt_reg[PIN_CLR] && state_reg == ST_ERROR && !err_evt
            ##1 !flt_reg[PIN_CLR] && !err_evt && state_reg == ST_ERROR;
    endsequence

    AST_POWERUP_IDLE: assert property (disable iff (1'b0)
        srst_in |=> state_reg == ST_INACTIVE &&
        !motor_drive_en_out)
        else $error("not inactive after reset");
    AST_RUN_START: assert property (state_reg == ST_INACTIVE &&
        flt_reg[PIN_RUN] && !err_evt |=> active)
        else $error("run switch did not start");
    AST_ERR_IDLE: assert property (state_reg == ST_INACTIVE &&
        err_evt |=> state_reg == ST_ERROR)
        else $error("error missed while inactive");
    AST_ACTIVE_OUT: assert property (active |->
        run_indicator_out && motor_drive_en_out)
        else $error("active without run lamp or drive");
    AST_ERR_RUN: assert property (active && err_evt |=>
        state_reg == ST_ERROR ##0 error_indicator_out)
        else $error("error missed while active");
    AST_ERR_LAMP: assert property (err_evt |=>
        error_indicator_out)
        else $error("error lamp not lit");
    AST_CLEAR: assert property (clr_on_off |=>
        state_reg == ST_INACTIVE)
        else $error("clear switch did not clear error");
    AST_SPEED: assert property (active |->
        speed_cmd_out == $past(speed_knob_in))
        else $error("speed not following knob");
    AST_SAMPLE_GAP: assert property (adc_start_out |=>
        !adc_start_out [*8])
        else $error("samples requested too often");
    AST_DEGREE: assert property (fi.feat_vld |=>
        abn_reg + norm_reg == DEG_FULL)
        else $error("probabilities do not sum to full");
    AST_STREAM: assert property (!active |=>
        !smp_vld_reg)
        else $error("sample streamed while not active");
    AST_ERR_SAFE: assert property (state_reg == ST_ERROR |->
        !motor_drive_en_out && !run_indicator_out)
        else $error("drive enabled in error state");
endmodule

// ===== tb/mfd_pc_model.sv
/*
 * PC tool model: 8N1 serial receiver at the agreed baud rate.
 * Assumes the line idles high and shares sys_clk_in.
 */
`timescale 1ns/10ps
module mfd_pc_model
    import mfd_pkg::*;
#(
    parameter int unsigned DIV = BAUD_DIV
)(
    // clock and line
    input wire logic sys_clk_in,
    input wire logic rx_in,
    // received byte
    output logic [7:0] byte_out,
    output logic stb_out,
    output logic frame_err_out
);
    initial begin
        stb_out = 1'b0;
        frame_err_out = 1'b0;
        forever begin
            @(negedge rx_in);
            // centre on the start bit, then one bit time per step
            repeat (DIV / 2) @(posedge sys_clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (DIV) @(posedge sys_clk_in);
                byte_out[i] <= rx_in;
            end
            repeat (DIV) @(posedge sys_clk_in);
            if (rx_in !== 1'b1) frame_err_out <= 1'b1;
            stb_out <= 1'b1;
            @(posedge sys_clk_in);
            stb_out <= 1'b0;
        end
    end
endmodule

// ===== tb/tb_top.sv
/*
 * Self-checking bench for mfd_top: APB, panel, ADC and serial.
 * Assumes mfd_pkg and the PC model are compiled first.
 */
`timescale 1ns/10ps
module tb_top
    import mfd_pkg::*;
;
    localparam int SDIV = 64;
    localparam int LIMIT = 95000;
    logic clk, rst, psel, pen, pwr, pready, pslverr, err;
    logic run_sw, clr_sw, rbtn, ovc, flt, adc_done, adc_start;
    logic run_led, err_led, drv, tx, irq, stb, ferr;
    logic [11:0] paddr, knob, adc_d, spd;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rxb;
    logic [7:0] rxq[$];
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;

    mfd_top #(.SAMPLE_DIV(SDIV)) i_dut (
        .sys_clk_in(clk), .srst_in(rst), .paddr_in(paddr),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .run_switch_in(run_sw),
        .error_clear_switch_in(clr_sw), .reset_button_in(rbtn),
        .overcurrent_in(ovc), .fault_in(flt), .speed_knob_in(knob),
        .adc_done_in(adc_done), .adc_data_in(adc_d),
        .adc_start_out(adc_start), .run_indicator_out(run_led),
        .error_indicator_out(err_led), .motor_drive_en_out(drv),
        .speed_cmd_out(spd), .pc_serial_tx_out(tx), .irq_out(irq));
    mfd_pc_model i_pc (.sys_clk_in(clk), .rx_in(tx), .byte_out(rxb),
        .stb_out(stb), .frame_err_out(ferr));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (stb === 1'b1) rxq.push_back(rxb);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwr <= w;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask
    // state field plus lamps and drive enable derived from it
    task automatic state(input logic [1:0] s);
        apb(1'b0, REG_STATUS, 32'h0);
        chk({30'h0, rd[1:0]}, {30'h0, s});
        chk({29'h0, run_led, err_led, drv},
            {29'h0, s == 2'b01, s == 2'b11, s == 2'b01});
    endtask
    task automatic sample(input logic [11:0] d);
        while (adc_start !== 1'b1) begin
            @(posedge clk);
        end
        adc_done <= 1'b1;
        adc_d <= d;
        @(posedge clk);
        adc_done <= 1'b0;
    endtask

    initial begin
        {psel, pen, pwr, run_sw, clr_sw, rbtn, ovc, flt, adc_done} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        adc_d = 12'h000;
        knob = 12'hABC;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk(REG_CTRL, 32'h1);
        rdchk(REG_BIN, 32'h4);
        rdchk(REG_GAIN, 32'h100);
        rdchk(REG_IRQ_MASK, 32'h0);
        state(2'b00);
        chk({20'h0, spd}, 32'h0);
        rdchk(12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, REG_IRQ_MASK, 32'h1);
        $display("test reset done");
        flt <= 1'b1;
        settle();
        state(2'b11);
        chk({31'h0, irq}, 32'h1);
        clr_sw <= 1'b1;
        settle();
        clr_sw <= 1'b0;
        settle();
        state(2'b11);
        flt <= 1'b0;
        rbtn <= 1'b1;
        settle();
        rbtn <= 1'b0;
        settle();
        state(2'b00);
        apb(1'b1, REG_IRQ_STAT, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h0);
        $display("test inactive error done");
        run_sw <= 1'b1;
        settle();
        state(2'b01);
        chk({20'h0, spd}, 32'hABC);
        knob <= 12'h123;
        settle();
        chk({20'h0, spd}, 32'h123);
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b1, REG_GAIN, 32'h1);
        // square wave at the fundamental bin, 0x700 then 0x900
        for (int i = 0; i < 256; i++) begin
            sample(i[5] ? 12'h900 : 12'h700);
        end
        settle();
        rdchk(REG_IRQ_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        rdchk(REG_FEAT1, 32'h10000);
        rdchk(REG_FEAT3, 32'h6000);
        apb(1'b0, REG_STATUS, 32'h0);
        chk({24'h0, rd[15:8]}, 32'h60);
        chk({24'h0, rd[23:16]}, 32'h9F);
        apb(1'b1, REG_IRQ_STAT, 32'h2);
        $display("test frame done");
        // let any byte still on the line finish before listening
        repeat (22000) @(posedge clk);
        apb(1'b1, REG_CTRL, 32'h1);
        rxq.delete();
        sample(12'h5A3);
        while (rxq.size() < 2) begin
            @(posedge clk);
        end
        chk({24'h0, rxq[0]}, 32'h05);
        chk({24'h0, rxq[1]}, 32'hA3);
        chk({31'h0, ferr}, 32'h0);
        $display("test stream done");
        ovc <= 1'b1;
        settle();
        state(2'b11);
        chk({20'h0, spd}, 32'h0);
        ovc <= 1'b0;
        run_sw <= 1'b0;
        clr_sw <= 1'b1;
        settle();
        clr_sw <= 1'b0;
        settle();
        state(2'b00);
        $display("test active error done");
        complete_run();
    end
endmodule
